//--- hw/rfcg_top.sv
// Function
// RQ1 - two counters share one gate interval
// RQ2 - gate opens on first input edge after arming
// RQ3 - control time elapsed, close on next edge
// RQ4 - hand both counts over after gate closes
// RQ5 - frequency is count ratio times reference rate
// RQ6 - counting reference is 400 MHz
// RQ7 - time resolution of 2.5 ns; y steps by 25 ns or more, one core cycle at best
// RQ8 - auto detect 5 or 10 MHz external reference
// RQ9 - flag external reference in use
// RQ10 - continuous 10 MHz standard output
// RQ11 - internal timed gate or external arm gate
// RQ12 - gate indicator on only while gate open
// RQ13 - limit indicator when result outside limits
// RQ14 - clear before open, hold until read
// RQ15 - reference counter never overflows at max time
`timescale 1ns/1ps
`include "rfcg_map.svh"

module rfcg_top #(
  parameter int P_CT0_CYC = `RFCG_CLK_HZ / 1000 * `RFCG_CT0_MS,
  parameter int P_CT1_CYC = `RFCG_CLK_HZ / 1000 * `RFCG_CT1_MS,
  parameter int P_CT2_CYC = `RFCG_CLK_HZ / 1000 * `RFCG_CT2_MS,
  parameter int P_CT3_CYC = `RFCG_CLK_HZ / 1000 * `RFCG_CT3_MS,
  parameter int P_DET_WIN_CYC = `RFCG_CLK_MHZ * `RFCG_DET_WIN_US
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_signal,
  input wire logic i_ext_arm,
  input wire logic i_ref_in,
  input wire logic i_arm,
  input wire logic i_read_done,
  input wire logic i_gate_source_select,
  input wire logic [1:0] i_control_time_sel,
  input wire rfcg_pkg::rfcg_limit_t i_limit,
  output rfcg_pkg::rfcg_counts_t o_result,
  output rfcg_pkg::rfcg_freq_t o_freq,
  output logic o_gate,
  output logic o_limit,
  output logic o_external_standard_indicator,
  output logic o_std_10mhz
);
  import rfcg_pkg::*;

  // ----------------------------------------------------------------------
  // derived constants
  // ----------------------------------------------------------------------
  // the reference count is kept in 2.5 ns ticks of a 400 MHz machine
  // clock; each 25 ns cycle of the core clock is worth ten such ticks
  localparam int STEP_INT = `RFCG_CLK_PS / `RFCG_TICK_PS;
  localparam int STEP_EXT5 = `RFCG_EXT5_PS / `RFCG_TICK_PS;
  localparam int STEP_EXT10 = `RFCG_EXT10_PS / `RFCG_TICK_PS;
  // reference rises that one detection window holds at 5 and at 10 MHz
  localparam int EXP5 = P_DET_WIN_CYC * `RFCG_EXT_LO_MHZ / `RFCG_CLK_MHZ;
  localparam int EXP10 = P_DET_WIN_CYC * `RFCG_EXT_HI_MHZ / `RFCG_CLK_MHZ;

  rfcg_state_t s_r;
  rfcg_state_t s_nxt;
  // divider operands and its one-cycle done pulse
  logic div_done;
  logic [63:0] div_quot;
  logic [63:0] div_num;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // a pin level is taken once the second and third stages agree
  function automatic logic sync_level(input logic [2:0] sy, input logic lvl);
    sync_level = (sy[1] == sy[2]) ? sy[2] : lvl;
  endfunction

  // one-cycle pulse on a rising synchronised level
  function automatic logic rise_of(input logic lvl_nxt, input logic lvl);
    rise_of = lvl_nxt & ~lvl;
  endfunction

  // edge count within one sixty-fourth of the expected value, plus one
  function automatic logic near(input logic [`RFCG_DET_W-1:0] cnt,
                                input int expect_cnt);
    int tol;
    tol = expect_cnt / 64 + 1;
    near = (32'(cnt) + 32'(tol) >= 32'(expect_cnt)) &&
           (32'(cnt) <= 32'(expect_cnt) + 32'(tol));
  endfunction

  // control time selection
  function automatic logic [`RFCG_TMR_W-1:0] ct_last(input logic [1:0] sel);
    case (sel)
      2'h0: ct_last = `RFCG_TMR_W'(P_CT0_CYC - 1);
      2'h1: ct_last = `RFCG_TMR_W'(P_CT1_CYC - 1);
      2'h2: ct_last = `RFCG_TMR_W'(P_CT2_CYC - 1);
      default: ct_last = `RFCG_TMR_W'(P_CT3_CYC - 1);
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // frequency arithmetic
  // ----------------------------------------------------------------------
  // f = x / y * 400 MHz, with y in 2.5 ns ticks [RQ5] [RQ6]
  assign div_num = 64'(s_r.x) * 64'(`RFCG_REF_HZ);

  // quotient is taken when done pulses; a new start overwrites it
  rfcg_div u_div (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_start(s_r.div_start),
    .i_num(div_num),
    .i_den(s_r.y),
    .o_done(div_done),
    .o_quot(div_quot)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic sig_rise;
    logic arm_rise;
    logic ref_rise;
    logic tick;
    logic [7:0] step;
    logic [`RFCG_HZ_W-1:0] hz;
    sig_rise = 1'b0;
    arm_rise = 1'b0;
    ref_rise = 1'b0;
    tick = 1'b0;
    step = 8'h00;
    hz = '0;
    s_nxt = s_r;
    s_nxt.div_start = 1'b0;

    // pin synchronisers; the input can be at most 10 MHz here, since
    // every edge must be seen by two samples of the 40 MHz clock
    s_nxt.sig_sy = {s_r.sig_sy[1:0], i_signal};
    s_nxt.arm_sy = {s_r.arm_sy[1:0], i_ext_arm};
    s_nxt.ref_sy = {s_r.ref_sy[1:0], i_ref_in};
    s_nxt.sig_lvl = sync_level(s_r.sig_sy, s_r.sig_lvl);
    s_nxt.arm_lvl = sync_level(s_r.arm_sy, s_r.arm_lvl);
    s_nxt.ref_lvl = sync_level(s_r.ref_sy, s_r.ref_lvl);
    sig_rise = rise_of(s_nxt.sig_lvl, s_r.sig_lvl);
    arm_rise = rise_of(s_nxt.arm_lvl, s_r.arm_lvl);
    ref_rise = rise_of(s_nxt.ref_lvl, s_r.ref_lvl);

    // 10 MHz standard out: the core clock divided by four [RQ10]
    // only as exact as the core clock; not slaved to the external input
    s_nxt.div10 = ~s_r.div10;
    if (s_r.div10) begin
      s_nxt.out10 = ~s_r.out10; // [RQ10]
    end

    // count reference edges over a fixed window and classify them
    // a window cut by a change of reference may misread once; the next
    // full window corrects it, so the standard lags by up to two windows
    if (ref_rise && (s_r.ref_edges != '1)) begin
      s_nxt.ref_edges = s_r.ref_edges + `RFCG_DET_W'(1);
    end
    if (s_r.win_cnt == `RFCG_DET_W'(P_DET_WIN_CYC - 1)) begin
      s_nxt.win_cnt = '0;
      s_nxt.ref_edges = '0;
      if (near(s_r.ref_edges, EXP10)) begin
        s_nxt.det_sel = STD_EXT10; // [RQ8]
      end else if (near(s_r.ref_edges, EXP5)) begin
        s_nxt.det_sel = STD_EXT5; // [RQ8]
      end else begin
        s_nxt.det_sel = STD_INT;
      end
    end else begin
      s_nxt.win_cnt = s_r.win_cnt + `RFCG_DET_W'(1);
    end
    // a switch of standard mid-gate would mix tick units, so it waits
    if (s_r.st != ST_OPEN) begin
      s_nxt.std_sel = s_r.det_sel; // [RQ8]
    end
    s_nxt.ext_ind = (s_r.std_sel != STD_INT); // [RQ9]

    // reference tick and its weight in 2.5 ns units [RQ7]
    // external ticks pass the same three-stage delay as the gate edges,
    // so the delay cancels out of y
    case (s_r.std_sel)
      STD_EXT5: begin
        tick = ref_rise;
        step = 8'(STEP_EXT5);
      end
      STD_EXT10: begin
        tick = ref_rise;
        step = 8'(STEP_EXT10);
      end
      default: begin
        tick = 1'b1;
        step = 8'(STEP_INT);
      end
    endcase

    // measurement sequence
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.gate = 1'b0; // [RQ12]
        if (i_arm) begin
          s_nxt.x = '0; // [RQ14]
          s_nxt.y = '0; // [RQ14]
          s_nxt.timer = '0;
          s_nxt.close_req = 1'b0;
          if (i_gate_source_select) begin
            s_nxt.st = ST_XWAIT; // [RQ11]
          end else begin
            s_nxt.st = ST_ARMED; // [RQ11]
          end
        end
      end
      ST_XWAIT: begin
        // external arm mode: the arm pin edge stands in for the start
        if (arm_rise) begin
          s_nxt.st = ST_ARMED; // [RQ11]
        end
      end
      ST_ARMED: begin
        // the opening rise only starts the gate; x counts from the next one
        if (sig_rise) begin
          s_nxt.gate = 1'b1; // [RQ2] [RQ12]
          s_nxt.st = ST_OPEN; // [RQ2]
        end
      end
      ST_OPEN: begin
        // both counters run inside the same gate [RQ1]
        // 40 bits of 2.5 ns ticks last over 45 minutes [RQ15]
        if (tick) begin
          s_nxt.y = s_r.y + `RFCG_Y_W'(step); // [RQ1] [RQ2]
        end
        if (sig_rise) begin
          s_nxt.x = s_r.x + `RFCG_X_W'(1); // [RQ1]
        end
        // the timer counts core cycles whatever standard feeds y
        if (!s_r.close_req) begin
          if (i_gate_source_select) begin
            s_nxt.close_req = arm_rise; // [RQ11]
          end else if (s_r.timer == ct_last(i_control_time_sel)) begin
            s_nxt.close_req = 1'b1; // [RQ3]
          end else begin
            s_nxt.timer = s_r.timer + `RFCG_TMR_W'(1);
          end
        end
        // closing waits for the next input edge, so x has no count error
        if (sig_rise && s_r.close_req) begin
          s_nxt.gate = 1'b0; // [RQ3] [RQ12]
          s_nxt.result_valid = 1'b1; // [RQ4]
          s_nxt.div_start = 1'b1; // [RQ5]
          s_nxt.st = ST_DIVIDE;
        end
      end
      ST_DIVIDE: begin
        // x and y stand still while the quotient is formed [RQ14]
        // an empty y, from a gate shorter than one external reference period, gives an
        // all-ones quotient that saturates like an overflow
        if (div_done) begin
          hz = (|div_quot[63:32]) ? '1 : div_quot[31:0];
          s_nxt.freq = hz; // [RQ5]
          s_nxt.freq_valid = 1'b1; // [RQ4]
          s_nxt.limit = i_limit.enable &&
                        ((hz > i_limit.upper) ||
                         (hz < i_limit.lower)); // [RQ13]
          s_nxt.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // counts hold until the processor says it has read them
        // a new arm is refused until then, so no result is lost unread
        if (i_read_done) begin
          s_nxt.result_valid = 1'b0; // [RQ14]
          s_nxt.freq_valid = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
        s_nxt.gate = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // one register holds all state, so reset and update stay together
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign o_result.event_count = s_r.x; // [RQ4]
  assign o_result.ref_count = s_r.y; // [RQ4]
  assign o_result.valid = s_r.result_valid;
  assign o_freq.hz = s_r.freq;
  assign o_freq.valid = s_r.freq_valid;
  assign o_gate = s_r.gate;
  assign o_limit = s_r.limit;
  assign o_external_standard_indicator = s_r.ext_ind;
  assign o_std_10mhz = s_r.out10;

endmodule

//--- hw/rfcg_map.svh
`ifndef RFCG_MAP_SVH
`define RFCG_MAP_SVH

// ----------------------------------------------------------------------
// clock and reference rates
// ----------------------------------------------------------------------
`define RFCG_CLK_HZ 32'h02625a00
`define RFCG_CLK_MHZ 32'h00000028
`define RFCG_REF_HZ 32'h17d78400
`define RFCG_CLK_PS 32'h000061a8
`define RFCG_TICK_PS 32'h000009c4
`define RFCG_EXT5_PS 32'h00030d40
`define RFCG_EXT10_PS 32'h000186a0
`define RFCG_EXT_LO_MHZ 32'h00000005
`define RFCG_EXT_HI_MHZ 32'h0000000a

// ----------------------------------------------------------------------
// control times in ms and reference detection window in us
// ----------------------------------------------------------------------
`define RFCG_CT0_MS 32'h00000001
`define RFCG_CT1_MS 32'h0000000a
`define RFCG_CT2_MS 32'h00000064
`define RFCG_CT3_MS 32'h000003e8
`define RFCG_DET_WIN_US 32'h000003e8

// ----------------------------------------------------------------------
// counter widths
// ----------------------------------------------------------------------
`define RFCG_X_W 32
`define RFCG_Y_W 40
`define RFCG_TMR_W 26
`define RFCG_DET_W 16
`define RFCG_HZ_W 32

`endif

//--- hw/rfcg_pkg.sv
`include "rfcg_map.svh"

package rfcg_pkg;

  // ----------------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XWAIT,
    ST_ARMED,
    ST_OPEN,
    ST_DIVIDE,
    ST_HOLD
  } rfcg_fsm_t;

  typedef enum logic [1:0] {
    STD_INT,
    STD_EXT5,
    STD_EXT10
  } rfcg_std_t;

  // ----------------------------------------------------------------------
  // carriers at the ports
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`RFCG_X_W-1:0] event_count;
    logic [`RFCG_Y_W-1:0] ref_count;
    logic valid;
  } rfcg_counts_t;

  typedef struct packed {
    logic [`RFCG_HZ_W-1:0] hz;
    logic valid;
  } rfcg_freq_t;

  typedef struct packed {
    logic enable;
    logic [`RFCG_HZ_W-1:0] upper;
    logic [`RFCG_HZ_W-1:0] lower;
  } rfcg_limit_t;

  // ----------------------------------------------------------------------
  // module state
  // ----------------------------------------------------------------------
  typedef struct packed {
    rfcg_fsm_t st;
    logic [2:0] sig_sy;
    logic [2:0] arm_sy;
    logic [2:0] ref_sy;
    logic sig_lvl;
    logic arm_lvl;
    logic ref_lvl;
    logic [`RFCG_X_W-1:0] x;
    logic [`RFCG_Y_W-1:0] y;
    logic [`RFCG_TMR_W-1:0] timer;
    logic close_req;
    logic gate;
    logic div_start;
    logic result_valid;
    logic [`RFCG_HZ_W-1:0] freq;
    logic freq_valid;
    logic limit;
    logic [`RFCG_DET_W-1:0] win_cnt;
    logic [`RFCG_DET_W-1:0] ref_edges;
    rfcg_std_t det_sel;
    rfcg_std_t std_sel;
    logic ext_ind;
    logic div10;
    logic out10;
  } rfcg_state_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [63:0] num;
    logic [`RFCG_Y_W-1:0] den;
    logic [`RFCG_Y_W:0] rem;
    logic [63:0] quot;
  } rfcg_div_t;

endpackage

//--- hw/rfcg_div.sv
`timescale 1ns/1ps
`include "rfcg_map.svh"

module rfcg_div (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [63:0] i_num,
  input wire logic [`RFCG_Y_W-1:0] i_den,
  output logic o_done,
  output logic [63:0] o_quot
);
  import rfcg_pkg::*;

  rfcg_div_t d_r;
  rfcg_div_t d_nxt;

  // ----------------------------------------------------------------------
  // restoring divider, one quotient bit per cycle
  // ----------------------------------------------------------------------
  // 64 cycles per result; slow but tiny, and a gate lasts far longer
  always_comb begin
    logic [`RFCG_Y_W:0] rem_sh;
    rem_sh = '0;
    d_nxt = d_r;
    d_nxt.done = 1'b0;
    if (!d_r.busy) begin
      if (i_start) begin
        d_nxt.busy = 1'b1;
        d_nxt.cnt = 6'h00;
        d_nxt.num = i_num;
        d_nxt.den = i_den;
        d_nxt.rem = '0;
        d_nxt.quot = 64'h0;
      end
    end else begin
      rem_sh = {d_r.rem[`RFCG_Y_W-1:0], d_r.num[63]};
      d_nxt.num = {d_r.num[62:0], 1'b0};
      if (rem_sh >= {1'b0, d_r.den}) begin
        d_nxt.rem = rem_sh - {1'b0, d_r.den};
        d_nxt.quot = {d_r.quot[62:0], 1'b1};
      end else begin
        d_nxt.rem = rem_sh;
        d_nxt.quot = {d_r.quot[62:0], 1'b0};
      end
      d_nxt.cnt = d_r.cnt + 6'h01;
      if (d_r.cnt == 6'h3f) begin
        d_nxt.busy = 1'b0;
        d_nxt.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign o_done = d_r.done;
  assign o_quot = d_r.quot;

endmodule

//--- sim/rfcg_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// port checker
// ----------------------------------------------------------------------
module rfcg_chk (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_read_done,
  input wire rfcg_pkg::rfcg_limit_t i_limit,
  input wire rfcg_pkg::rfcg_counts_t o_result,
  input wire rfcg_pkg::rfcg_freq_t o_freq,
  input wire logic o_gate,
  input wire logic o_limit,
  input wire logic o_std_10mhz
);
  import rfcg_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // event count starts from zero at the opening edge
  property p_open_clear;
    $rose(o_gate) |-> o_result.event_count == '0 && !o_result.valid;
  endproperty
  a_open_clear: assert property (p_open_clear)
    else $error("counts not clear at gate open");
  // no result is offered while the gate is open
  property p_gate_excl;
    o_gate |-> !o_result.valid && !o_freq.valid;
  endproperty
  a_gate_excl: assert property (p_gate_excl)
    else $error("result valid while gate open");
  // closing hands the counts over at once
  property p_close_result;
    $fell(o_gate) |-> ##[0:1] o_result.valid;
  endproperty
  a_close_result: assert property (p_close_result)
    else $error("no result after gate close");
  // counts frozen while the processor may read them
  property p_hold;
    o_result.valid ##1 o_result.valid |-> $stable(o_result.event_count)
      && $stable(o_result.ref_count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counts moved before read");
  // the divider needs about 65 cycles
  property p_div_time;
    $rose(o_result.valid) |-> ##[60:70] $rose(o_freq.valid);
  endproperty
  a_div_time: assert property (p_div_time)
    else $error("frequency late");
  // limit flag follows the new result
  property p_limit;
    $rose(o_freq.valid) |-> o_limit == (i_limit.enable &&
      (o_freq.hz > i_limit.upper || o_freq.hz < i_limit.lower));
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit flag wrong");
  // a read releases both results
  property p_read;
    o_freq.valid && i_read_done |=> !o_result.valid && !o_freq.valid;
  endproperty
  a_read: assert property (p_read)
    else $error("read not taken");
  // standard output is clock over four
  property p_std;
    $changed(o_std_10mhz) |=> $stable(o_std_10mhz) ##1 $changed(o_std_10mhz);
  endproperty
  a_std: assert property (p_std)
    else $error("standard output not clock over four");
endmodule

bind rfcg_top rfcg_chk chk_u (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_read_done(i_read_done),
  .i_limit(i_limit), .o_result(o_result), .o_freq(o_freq),
  .o_gate(o_gate), .o_limit(o_limit), .o_std_10mhz(o_std_10mhz)
);

//--- sim/rfcg_src.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// measured source and external reference
// ----------------------------------------------------------------------
module rfcg_src (
  input wire logic [15:0] i_half_ns,
  input wire logic [1:0] i_ref_mode,
  output logic o_signal = 1'b0,
  output logic o_ref = 1'b0
);
  // steps stay on a 25 ns grid so no edge meets a rising clock edge
  always begin
    if (i_half_ns == 16'h0000) begin
      o_signal = 1'b0;
      #25;
    end else begin
      #(i_half_ns) o_signal = ~o_signal;
    end
  end
  // mode 1 gives 5 MHz, mode 2 gives 10 MHz, else an idle line
  always begin
    if (i_ref_mode == 2'h0 || i_ref_mode == 2'h3) begin
      o_ref = 1'b0;
      #25;
    end else begin
      #((i_ref_mode == 2'h2) ? 50 : 100) o_ref = ~o_ref;
    end
  end
endmodule

//--- sim/rfcg_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, a, e); end end
`define WAITC(c) begin for (n = 0; n < 9000 && !(c); n++) \
  @(negedge i_clock); \
  if (n == 9000) begin miscompares++; give_verdict(); end end

module rfcg_bench;
  import rfcg_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_signal, i_ref_in, p;
  logic i_ext_arm = 1'b0;
  logic i_arm = 1'b0;
  logic i_read_done = 1'b0;
  logic i_gate_source_select = 1'b0;
  logic [1:0] i_control_time_sel = 2'h0;
  rfcg_limit_t i_limit = '0;
  rfcg_counts_t o_result;
  rfcg_freq_t o_freq;
  logic o_gate, o_limit, o_external_standard_indicator, o_std_10mhz;
  logic [15:0] half_ns = 16'h0064;
  logic [1:0] ref_mode = 2'h0;
  logic [15:0] rnd = 16'h0008;
  int ct_tab[4] = '{200, 400, 800, 1600};
  int miscompares = 0;
  int tests_run = 0;
  int n, k, f;
  logic [39:0] y_exp;
  logic lim_exp;

  rfcg_top #(.P_CT0_CYC(200), .P_CT1_CYC(400), .P_CT2_CYC(800),
    .P_CT3_CYC(1600), .P_DET_WIN_CYC(800)) dut_u (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_signal(i_signal),
    .i_ext_arm(i_ext_arm), .i_ref_in(i_ref_in), .i_arm(i_arm),
    .i_read_done(i_read_done), .i_gate_source_select(i_gate_source_select),
    .i_control_time_sel(i_control_time_sel), .i_limit(i_limit),
    .o_result(o_result), .o_freq(o_freq), .o_gate(o_gate),
    .o_limit(o_limit), .o_std_10mhz(o_std_10mhz),
    .o_external_standard_indicator(o_external_standard_indicator));

  rfcg_src src_u (.i_half_ns(half_ns), .i_ref_mode(ref_mode),
    .o_signal(i_signal), .o_ref(i_ref_in));

  always #12.5 i_clock = ~i_clock;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one-cycle pulse: 0 arms, 1 reports the counts read
  task automatic strobe(input int which);
    @(posedge i_clock);
    if (which == 0) i_arm <= 1'b1;
    else i_read_done <= 1'b1;
    @(posedge i_clock);
    i_arm <= 1'b0;
    i_read_done <= 1'b0;
  endtask

  // pin level held six cycles, three times what the synchroniser needs
  task automatic ext_pulse();
    @(posedge i_clock) i_ext_arm <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_ext_arm <= 1'b0;
    repeat (6) @(posedge i_clock);
  endtask

  // ----------------------------------------------------------------------
  // one measurement against the integer model of the source
  // ----------------------------------------------------------------------
  task automatic measure(input logic ext, input int ct);
    // eight steps so every bit of the word has moved between tests
    repeat (8) rnd = lfsr(rnd);
    @(posedge i_clock);
    i_limit.enable <= rnd[0];
    i_limit.upper <= 32'h004c4b40 + {24'h0, rnd[7:0]} - 32'h0000007f;
    i_limit.lower <= 32'h004c4b40 - {24'h0, rnd[15:8]} + 32'h0000007f;
    i_gate_source_select <= ext;
    strobe(0);
    if (ext) begin
      repeat (40) @(negedge i_clock);
      `CHK(o_gate, 1'b0)
      ext_pulse();
    end
    `WAITC(o_gate === 1'b1)
    // internal gate: a second arm inside the gate must not restart it; external arm gate: this pin pulse closes it
    if (ext) begin
      repeat (ct) @(posedge i_clock);
      ext_pulse();
    end else begin
      strobe(0);
    end
    `WAITC(o_result.valid === 1'b1)
    strobe(1);
    @(negedge i_clock);
    `CHK(o_result.valid, 1'b1)
    `WAITC(o_freq.valid === 1'b1)
    f = 1000000000 / (2 * half_ns);
    y_exp = 40'(o_result.event_count) * 40'(400000000 / f);
    lim_exp = i_limit.enable && (f > i_limit.upper || f < i_limit.lower);
    `CHK(o_result.ref_count, y_exp)
    k = 8 * o_result.event_count;
    `CHK(k >= ct && k <= ct + (ext ? 40 : 16), 1'b1)
    `CHK(o_freq.hz, 32'(f))
    `CHK(o_limit, lim_exp)
    strobe(1);
    @(negedge i_clock);
    `CHK({o_result.valid, o_freq.valid}, 2'h0)
    $display("measurement ext=%0d ct=%0d done", ext, ct);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(negedge i_clock);
    `CHK({o_gate, o_result.valid, o_freq.valid, o_limit}, 4'h0)
    strobe(1);
    k = 0;
    @(negedge i_clock);
    p = o_std_10mhz;
    for (n = 0; n < 40; n++) begin
      @(negedge i_clock);
      k += (o_std_10mhz !== p);
      p = o_std_10mhz;
    end
    `CHK(k, 20)
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clock) i_control_time_sel <= 2'(i);
      measure(1'b0, ct_tab[i]);
    end
    measure(1'b1, 400);
    for (int m = 2; m >= 0; m--) begin
      ref_mode <= 2'(m);
      repeat (2000) @(negedge i_clock);
      `CHK(o_external_standard_indicator, m != 0)
      measure(1'b0, 1600);
    end
    give_verdict();
  end
endmodule
